//--- core/etc_timer.sv
// Eight-bit timer with compare unit behind an AXI4-Lite slave
//
// The implementer's own choices: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/10ps
`default_nettype none
`include "etc_defs.svh"
module etc_timer
  import etc_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // AXI4-Lite write address
  input wire logic [`ETC_AW-1:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  // AXI4-Lite read address
  input wire logic [`ETC_AW-1:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  // External count pin
  input wire logic ext_clk_i,
  // Waveform pin
  output logic oc_pin_o,
  output logic oc_pin_oe_o,
  // Interrupt handshake with the cpu
  input wire logic global_int_en_i,
  input wire logic cmp_irq_ack_i,
  input wire logic ovf_irq_ack_i,
  output logic cmp_irq_o,
  output logic ovf_irq_o
);

  // Address decode shared by read and write
  function automatic logic etc_mapped(input logic [`ETC_AW-1:0] a);
    etc_mapped = (a == `ETC_A_CTRL) || (a == `ETC_A_COUNT) ||
                 (a == `ETC_A_COMP) || (a == `ETC_A_FLAGS) ||
                 (a == `ETC_A_MASK) || (a == `ETC_A_PIN);
  endfunction : etc_mapped

  // Bus holding state
  logic aw_full_reg; // Write address held
  logic aw_full_next;
  logic [`ETC_AW-1:0] aw_addr_reg;
  logic w_full_reg; // Write data held
  logic w_full_next;
  logic [7:0] w_data_reg; // Only low byte matters
  logic w_lane_reg; // Byte lane 0 enabled
  logic awready_reg;
  logic wready_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic arready_reg;
  logic rvalid_reg;
  logic [1:0] rresp_reg;
  logic [31:0] rdata_reg;
  logic wr_go; // Both halves present
  logic wr_en; // Mapped write with lane 0

  // Software visible state
  logic [2:0] cs_reg; // Clock select field
  etc_wgm_t wgm_reg; // Waveform mode field
  logic [1:0] com_reg; // Compare output mode bits
  logic [7:0] cnt_reg; // Count value
  logic [7:0] ocr_reg; // Active compare value
  logic [7:0] buf_reg; // Compare buffer
  logic ovf_reg; // Overflow flag
  logic cmp_reg; // Compare match flag
  logic ovf_mask_reg;
  logic cmp_mask_reg;
  logic pin_dir_reg; // Waveform pin direction bit
  logic port_val_reg; // Plain port output value

  // Timer core state
  logic [`ETC_PRE_W-1:0] pre_reg; // Free-running prescaler
  logic ext_s1_reg; // Synchroniser first stage
  logic ext_s2_reg; // Synchroniser second stage
  logic ext_d_reg; // Edge detect history
  logic dir_up_reg; // Phase correct direction
  logic blk_reg; // Match block after count write
  logic oc_reg; // Internal waveform output
  logic oc_next;
  logic cmp_irq_reg;
  logic ovf_irq_reg;
  logic oc_pin_reg;
  logic oc_oe_reg;

  // Decoded strobes and conditions
  logic tick; // Timer clock pulse
  logic is_pwm;
  logic wr_ctrl;
  logic wr_cnt;
  logic wr_comp;
  logic wr_flags;
  logic cmp_eq; // Raw comparator
  logic match_hit; // Effective match this tick
  logic is_top;
  logic is_bot;
  logic ovf_set;
  logic force_cmp;
  logic [7:0] cnt_step;
  logic [1:0] com_eff; // Output mode in force this cycle
  etc_wgm_t wgm_eff; // Waveform mode in force this cycle

  // Outputs straight from flops
  assign s_axi_awready_o = awready_reg;
  assign s_axi_wready_o = wready_reg;
  assign s_axi_bvalid_o = bvalid_reg;
  assign s_axi_bresp_o = bresp_reg;
  assign s_axi_arready_o = arready_reg;
  assign s_axi_rvalid_o = rvalid_reg;
  assign s_axi_rresp_o = rresp_reg;
  assign s_axi_rdata_o = rdata_reg;
  assign oc_pin_o = oc_pin_reg;
  assign oc_pin_oe_o = oc_oe_reg;
  assign cmp_irq_o = cmp_irq_reg;
  assign ovf_irq_o = ovf_irq_reg;

  // Write channel bookkeeping
  assign wr_go = aw_full_reg && w_full_reg && !bvalid_reg;
  assign wr_en = wr_go && w_lane_reg && etc_mapped(aw_addr_reg);
  assign wr_ctrl = wr_en && (aw_addr_reg == `ETC_A_CTRL);
  assign wr_cnt = wr_en && (aw_addr_reg == `ETC_A_COUNT);
  assign wr_comp = wr_en && (aw_addr_reg == `ETC_A_COMP);
  assign wr_flags = wr_en && (aw_addr_reg == `ETC_A_FLAGS);

  // Next fill state of both write halves
  always_comb
  begin
    aw_full_next = aw_full_reg;
    w_full_next = w_full_reg;
    if (wr_go)
    begin
      aw_full_next = 1'b0;
      w_full_next = 1'b0;
    end
    else
    begin
      if (s_axi_awvalid_i && awready_reg)
        aw_full_next = 1'b1;
      if (s_axi_wvalid_i && wready_reg)
        w_full_next = 1'b1;
    end
  end

  // Address and data may arrive in either order
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      awready_reg <= 1'b0;
      wready_reg <= 1'b0;
      aw_addr_reg <= `ETC_A_CTRL;
      w_data_reg <= `ETC_BOT;
      w_lane_reg <= 1'b0;
    end
    else
    begin
      aw_full_reg <= aw_full_next;
      w_full_reg <= w_full_next;
      awready_reg <= !aw_full_next;
      wready_reg <= !w_full_next;
      if (s_axi_awvalid_i && awready_reg)
        aw_addr_reg <= s_axi_awaddr_i;
      if (s_axi_wvalid_i && wready_reg)
      begin
        w_data_reg <= s_axi_wdata_i[7:0];
        w_lane_reg <= s_axi_wstrb_i[0];
      end
    end
  end

  // Write response, error for unmapped offsets
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      bvalid_reg <= 1'b0;
      bresp_reg <= `ETC_OKAY;
    end
    else if (wr_go)
    begin
      bvalid_reg <= 1'b1;
      bresp_reg <= etc_mapped(aw_addr_reg) ? `ETC_OKAY : `ETC_SLVERR;
    end
    else if (s_axi_bready_i)
      bvalid_reg <= 1'b0;
  end

  // Read path, one access in flight
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rresp_reg <= `ETC_OKAY;
      rdata_reg <= 32'h0000_0000;
    end
    else if (s_axi_arvalid_i && arready_reg)
    begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b1;
      rresp_reg <= etc_mapped(s_axi_araddr_i) ? `ETC_OKAY : `ETC_SLVERR;
      rdata_reg <= 32'h0000_0000;
      case (s_axi_araddr_i)
        // Force strobe always reads zero
        `ETC_A_CTRL: rdata_reg[6:0] <= {com_reg, wgm_reg, cs_reg};
        `ETC_A_COUNT: rdata_reg[7:0] <= cnt_reg;
        `ETC_A_COMP: rdata_reg[7:0] <= is_pwm ? buf_reg : ocr_reg;
        `ETC_A_FLAGS: rdata_reg[1:0] <= {cmp_reg, ovf_reg};
        `ETC_A_MASK: rdata_reg[1:0] <= {cmp_mask_reg, ovf_mask_reg};
        `ETC_A_PIN: rdata_reg[1:0] <= {port_val_reg, pin_dir_reg};
        default: rdata_reg <= 32'h0000_0000;
      endcase
    end
    else if (rvalid_reg && s_axi_rready_i)
    begin
      rvalid_reg <= 1'b0;
      arready_reg <= 1'b1;
    end
    else if (!rvalid_reg)
      arready_reg <= 1'b1;
  end

  // Control fields; mode change leaves oc_reg alone
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      cs_reg <= ETC_STOP;
      wgm_reg <= ETC_NORMAL;
      com_reg <= `ETC_COM_OFF;
    end
    else if (wr_ctrl)
    begin
      cs_reg <= w_data_reg[`ETC_F_CS];
      wgm_reg <= etc_wgm_t'(w_data_reg[`ETC_F_WGM]);
      com_reg <= w_data_reg[`ETC_F_COM];
    end
  end

  // Mask and port registers
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      ovf_mask_reg <= 1'b0;
      cmp_mask_reg <= 1'b0;
      pin_dir_reg <= 1'b0;
      port_val_reg <= 1'b0;
    end
    else if (wr_en)
    begin
      if (aw_addr_reg == `ETC_A_MASK)
      begin
        ovf_mask_reg <= w_data_reg[`ETC_B_OVF];
        cmp_mask_reg <= w_data_reg[`ETC_B_CMP];
      end
      if (aw_addr_reg == `ETC_A_PIN)
      begin
        pin_dir_reg <= w_data_reg[`ETC_B_DIR];
        port_val_reg <= w_data_reg[`ETC_B_PORT];
      end
    end
  end

  // External pin passes two flops before the edge detector
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      ext_s1_reg <= 1'b0;
      ext_s2_reg <= 1'b0;
      ext_d_reg <= 1'b0;
    end
    else
    begin
      ext_s1_reg <= ext_clk_i;
      ext_s2_reg <= ext_s1_reg;
      ext_d_reg <= ext_s2_reg;
    end
  end

  // Prescaler runs free, so first count may come early
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
      pre_reg <= '0;
    else
      pre_reg <= pre_reg + 1'b1;
  end

  // Timer clock pulse
  always_comb
  begin
    case (etc_cs_t'(cs_reg))
      ETC_STOP: tick = 1'b0;
      ETC_DIV1: tick = 1'b1;
      ETC_DIV8: tick = &pre_reg[2:0];
      ETC_DIV64: tick = &pre_reg[5:0];
      ETC_DIV256: tick = &pre_reg[7:0];
      ETC_DIV1024: tick = &pre_reg[9:0];
      ETC_EXT_FALL: tick = ext_d_reg && !ext_s2_reg;
      ETC_EXT_RISE: tick = !ext_d_reg && ext_s2_reg;
      default: tick = 1'b0;
    endcase
  end

  // Comparator and extremes
  assign is_pwm = (wgm_reg == ETC_PHASE) || (wgm_reg == ETC_FAST);
  assign cmp_eq = (cnt_reg == ocr_reg);
  assign match_hit = tick && cmp_eq && !blk_reg;
  assign is_top = (cnt_reg == `ETC_MAX);
  assign is_bot = (cnt_reg == `ETC_BOT);
  // A control write's own fields govern its strobe, not the stale ones
  assign com_eff = wr_ctrl ? w_data_reg[`ETC_F_COM] : com_reg;
  assign wgm_eff = wr_ctrl ? etc_wgm_t'(w_data_reg[`ETC_F_WGM]) : wgm_reg;
  assign force_cmp = wr_ctrl && w_data_reg[`ETC_B_FOC] &&
                     (wgm_eff == ETC_NORMAL || wgm_eff == ETC_CTC);

  // Next count; output mode bits play no part
  always_comb
  begin
    case (wgm_reg)
      ETC_NORMAL: cnt_step = cnt_reg + `ETC_ONE;
      ETC_CTC: cnt_step = cmp_eq ? `ETC_BOT : cnt_reg + `ETC_ONE;
      ETC_FAST: cnt_step = cnt_reg + `ETC_ONE;
      ETC_PHASE:
      begin
        if (dir_up_reg)
          cnt_step = is_top ? cnt_reg - `ETC_ONE : cnt_reg + `ETC_ONE;
        else
          cnt_step = is_bot ? cnt_reg + `ETC_ONE : cnt_reg - `ETC_ONE;
      end
      default: cnt_step = cnt_reg;
    endcase
  end

  // Counter register
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
      cnt_reg <= `ETC_BOT;
    else if (wr_cnt)
      cnt_reg <= w_data_reg;
    else if (tick)
      cnt_reg <= cnt_step;
  end

  // Count direction, only meaningful in phase correct
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
      dir_up_reg <= 1'b1;
    else if (wgm_reg != ETC_PHASE)
      dir_up_reg <= 1'b1;
    else if (tick && is_top)
      dir_up_reg <= 1'b0;
    else if (tick && is_bot)
      dir_up_reg <= 1'b1;
  end

  // Block flag lives until the next tick, even when stopped
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
      blk_reg <= 1'b0;
    else if (wr_cnt)
      blk_reg <= 1'b1;
    else if (tick)
      blk_reg <= 1'b0;
  end

  // Compare value and its buffer
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      ocr_reg <= `ETC_BOT;
      buf_reg <= `ETC_BOT;
    end
    else
    begin
      if (wr_comp && is_pwm)
        buf_reg <= w_data_reg;
      if (wr_comp && !is_pwm)
        ocr_reg <= w_data_reg;
      else if (is_pwm && tick && is_top)
        ocr_reg <= buf_reg;
    end
  end

  // Overflow condition per mode
  always_comb
  begin
    if (wgm_reg == ETC_PHASE)
      ovf_set = tick && is_bot && !dir_up_reg;
    else
      ovf_set = tick && is_top;
  end

  // Flags; a set in the same cycle beats any clear
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      ovf_reg <= 1'b0;
      cmp_reg <= 1'b0;
    end
    else
    begin
      ovf_reg <= ovf_set || (ovf_reg && !ovf_irq_ack_i &&
                 !(wr_flags && w_data_reg[`ETC_B_OVF]));
      cmp_reg <= match_hit || (cmp_reg && !cmp_irq_ack_i &&
                 !(wr_flags && w_data_reg[`ETC_B_CMP]));
    end
  end

  // Waveform output next value
  always_comb
  begin
    oc_next = oc_reg;
    if (com_eff != `ETC_COM_OFF)
    begin
      case (wgm_eff)
        ETC_NORMAL, ETC_CTC:
        begin
          if (match_hit || force_cmp)
          begin
            case (com_eff)
              `ETC_COM_TGL: oc_next = !oc_reg;
              `ETC_COM_CLR: oc_next = 1'b0;
              `ETC_COM_SET: oc_next = 1'b1;
              default: oc_next = oc_reg;
            endcase
          end
        end
        ETC_FAST:
        begin
          if (match_hit)
            oc_next = (com_eff == `ETC_COM_TGL) ? !oc_reg :
                      (com_eff == `ETC_COM_SET);
          // Bottom action wins so compare at max gives a flat level
          if (tick && is_top && com_eff != `ETC_COM_TGL)
            oc_next = (com_eff == `ETC_COM_CLR);
        end
        ETC_PHASE:
        begin
          if (match_hit && com_eff != `ETC_COM_TGL)
            oc_next = dir_up_reg ^ (com_eff == `ETC_COM_CLR);
        end
        default: oc_next = oc_reg;
      endcase
    end
  end

  // Waveform output register
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
      oc_reg <= 1'b0;
    else
      oc_reg <= oc_next;
  end

  // Pin drive; direction stays with the direction bit
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      oc_pin_reg <= 1'b0;
      oc_oe_reg <= 1'b0;
    end
    else
    begin
      oc_pin_reg <= (com_reg != `ETC_COM_OFF) ? oc_reg : port_val_reg;
      oc_oe_reg <= pin_dir_reg;
    end
  end

  // Interrupt requests, one cycle behind the flags
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      cmp_irq_reg <= 1'b0;
      ovf_irq_reg <= 1'b0;
    end
    else
    begin
      cmp_irq_reg <= cmp_reg && cmp_mask_reg && global_int_en_i &&
                     !cmp_irq_ack_i;
      ovf_irq_reg <= ovf_reg && ovf_mask_reg && global_int_en_i &&
                     !ovf_irq_ack_i;
    end
  end

endmodule : etc_timer
`default_nettype wire

//--- core/etc_defs.svh
// Constants for the eight-bit timer compare unit
`ifndef ETC_DEFS_SVH
`define ETC_DEFS_SVH
`define ETC_AW 5
`define ETC_A_CTRL 5'h00
`define ETC_A_COUNT 5'h04
`define ETC_A_COMP 5'h08
`define ETC_A_FLAGS 5'h0C
`define ETC_A_MASK 5'h10
`define ETC_A_PIN 5'h14
`define ETC_F_CS 2:0
`define ETC_F_WGM 4:3
`define ETC_F_COM 6:5
`define ETC_B_FOC 7
`define ETC_B_OVF 0
`define ETC_B_CMP 1
`define ETC_B_DIR 0
`define ETC_B_PORT 1
`define ETC_MAX 8'hFF
`define ETC_BOT 8'h00
`define ETC_ONE 8'h01
`define ETC_PRE_W 10
`define ETC_COM_OFF 2'h0
`define ETC_COM_TGL 2'h1
`define ETC_COM_CLR 2'h2
`define ETC_COM_SET 2'h3
`define ETC_OKAY 2'h0
`define ETC_SLVERR 2'h2
`endif

//--- core/etc_pkg.sv
// Types for the eight-bit timer compare unit
package etc_pkg;
  // Waveform modes, code as in the control field
  typedef enum logic [1:0] {
    ETC_NORMAL = 2'b00,
    ETC_PHASE = 2'b01,
    ETC_CTC = 2'b10,
    ETC_FAST = 2'b11
  } etc_wgm_t;
  // Timer clock sources
  typedef enum logic [2:0] {
    ETC_STOP = 3'b000,
    ETC_DIV1 = 3'b001,
    ETC_DIV8 = 3'b010,
    ETC_DIV64 = 3'b011,
    ETC_DIV256 = 3'b100,
    ETC_DIV1024 = 3'b101,
    ETC_EXT_FALL = 3'b110,
    ETC_EXT_RISE = 3'b111
  } etc_cs_t;
endpackage : etc_pkg

//--- sim/etc_timer_properties.sv
// Port-level checker for the eight-bit timer compare unit
`timescale 1ns/10ps
`default_nettype none
`include "etc_defs.svh"
module etc_timer_properties
  import etc_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // Bus write side
  input wire logic s_axi_awvalid_i,
  input wire logic s_axi_awready_o,
  input wire logic s_axi_wvalid_i,
  input wire logic s_axi_wready_o,
  input wire logic [1:0] s_axi_bresp_o,
  input wire logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  // Bus read side
  input wire logic s_axi_arvalid_i,
  input wire logic s_axi_arready_o,
  input wire logic [31:0] s_axi_rdata_o,
  input wire logic [1:0] s_axi_rresp_o,
  input wire logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  // Pin and interrupts
  input wire logic oc_pin_o,
  input wire logic global_int_en_i,
  input wire logic cmp_irq_o,
  input wire logic ovf_irq_o
);
  // Single domain, so one clock and one reset for all
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  // Both write halves taken at one edge
  sequence s_wr_taken;
    s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
  endsequence
  // Read address taken
  sequence s_rd_taken;
    s_axi_arvalid_i && s_axi_arready_o;
  endsequence
  property p_wr_answer;
    s_wr_taken |=> !s_axi_awready_o ##[0:2] s_axi_bvalid_o;
  endproperty
  property p_b_done;
    s_axi_bvalid_o && s_axi_bready_i |=> !s_axi_bvalid_o ##[0:2] s_axi_awready_o;
  endproperty
  property p_b_code;
    s_axi_bvalid_o |-> s_axi_bresp_o == `ETC_OKAY || s_axi_bresp_o == `ETC_SLVERR;
  endproperty
  property p_rd_answer;
    s_rd_taken |=> !s_axi_arready_o ##[0:1] s_axi_rvalid_o;
  endproperty
  property p_r_hold;
    s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o);
  endproperty
  property p_r_done;
    s_axi_rvalid_o && s_axi_rready_i |=> !s_axi_rvalid_o ##[0:2] s_axi_arready_o;
  endproperty
  // Only the low byte carries data; an error read gives zero
  property p_r_byte;
    s_axi_rvalid_o |-> s_axi_rdata_o[31:8] == 24'h0 &&
      (s_axi_rresp_o != `ETC_SLVERR || s_axi_rdata_o == 32'h0);
  endproperty
  // Requests only pass while the cpu enable was up
  property p_cmp_gate;
    cmp_irq_o |-> $past(global_int_en_i);
  endproperty
  property p_ovf_gate;
    ovf_irq_o |-> $past(global_int_en_i);
  endproperty
  // Output low straight out of reset
  property p_reset_out;
    $fell(rst_i) |-> !oc_pin_o && !cmp_irq_o && !ovf_irq_o;
  endproperty
  a_wr_answer: assert property (p_wr_answer) else $error("write answer missing");
  a_b_done: assert property (p_b_done) else $error("write response not retired");
  a_b_code: assert property (p_b_code) else $error("bad write response code");
  a_rd_answer: assert property (p_rd_answer) else $error("read answer missing");
  a_r_hold: assert property (p_r_hold) else $error("read data moved while stalled");
  a_r_done: assert property (p_r_done) else $error("read not retired");
  a_r_byte: assert property (p_r_byte) else $error("read data upper bits set");
  a_cmp_gate: assert property (p_cmp_gate) else $error("compare request ungated");
  a_ovf_gate: assert property (p_ovf_gate) else $error("overflow request ungated");
  a_reset_out: assert property (p_reset_out) else $error("pin high after reset");
endmodule : etc_timer_properties
bind etc_timer etc_timer_properties i_props (.*);
`default_nettype wire

//--- sim/etc_timer_tb.sv
// Bus-level bench for the eight-bit timer compare unit
`timescale 1ns/10ps
`default_nettype none
`include "etc_defs.svh"
module etc_timer_tb
  import etc_pkg::*;
;
  // Clock, reset and bus drives
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [`ETC_AW-1:0] awaddr = 5'h00;
  logic [`ETC_AW-1:0] araddr = 5'h00;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b1;
  logic [31:0] wdata = 32'h0;
  // Cpu side
  logic gie = 1'b0;
  logic cack = 1'b0;
  logic oack = 1'b0;
  // Design answers
  logic awready, wready, bvalid, arready, rvalid;
  logic pin, pin_oe, cirq, oirq;
  logic [1:0] bresp, rresp, r;
  logic [31:0] rdata, d;
  // Forced-match table: strobe, output mode, expected pin
  logic [3:0] tbl [7] = '{4'hB, 4'hA, 4'hF, 4'hC, 4'hF, 4'h8, 4'h3};
  int n_fail = 0;
  int total_checks = 0;
  int i;

  // 125 MHz clock
  always #4 ref_clk_i = ~ref_clk_i;

  etc_timer i_dut
  (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .s_axi_awaddr_i(awaddr),
    .s_axi_awvalid_i(awvalid),
    .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(4'hF),
    .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready),
    .s_axi_bresp_o(bresp),
    .s_axi_bvalid_o(bvalid),
    .s_axi_bready_i(1'b1),
    .s_axi_araddr_i(araddr),
    .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready),
    .s_axi_rdata_o(rdata),
    .s_axi_rresp_o(rresp),
    .s_axi_rvalid_o(rvalid),
    .s_axi_rready_i(rready),
    .ext_clk_i(1'b0),
    .oc_pin_o(pin),
    .oc_pin_oe_o(pin_oe),
    .global_int_en_i(gie),
    .cmp_irq_ack_i(cack),
    .ovf_irq_ack_i(oack),
    .cmp_irq_o(cirq),
    .ovf_irq_o(oirq)
  );

  // Compare and count
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // Closing report, the only way out
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : give_verdict

  // A bus wait ran out
  task automatic give_up();
    check("bus answer", 32'h0, 32'h1);
    give_verdict();
  endtask : give_up

  // Control byte from its fields
  function automatic logic [7:0] ctl(etc_cs_t c, etc_wgm_t m, logic [1:0] o, logic f);
    return {f, o, m, c};
  endfunction : ctl

  // One write; both halves offered together, each dropped when taken
  task automatic wr(input logic [4:0] a, input logic [7:0] v);
    int k;
    logic got;
    got = 1'b0;
    awaddr <= a;
    wdata <= {24'h0, v};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    for (k = 0; k < 40 && !got; k++)
    begin
      @(posedge ref_clk_i);
      if (awready === 1'b1)
        awvalid <= 1'b0;
      if (wready === 1'b1)
        wvalid <= 1'b0;
      got = (bvalid === 1'b1);
    end
    if (!got)
      give_up();
    check("bresp", 32'(bresp), 32'(`ETC_OKAY));
  endtask : wr

  // One read; rready held low for st cycles to stall the answer
  task automatic rd(input logic [4:0] a, input int st);
    int k;
    logic got;
    got = 1'b0;
    araddr <= a;
    arvalid <= 1'b1;
    if (st > 0)
      rready <= 1'b0;
    for (k = 0; k < 40 && !got; k++)
    begin
      @(posedge ref_clk_i);
      if (arready === 1'b1)
        arvalid <= 1'b0;
      got = (rvalid === 1'b1 && rready === 1'b1);
      d = rdata;
      r = rresp;
      if (k + 1 == st)
        rready <= 1'b1;
    end
    if (!got)
      give_up();
  endtask : rd

  // Read and compare one register
  task automatic chk(input logic [4:0] a, input logic [7:0] e, input string n);
    rd(a, 0);
    check(n, d, {24'h0, e});
  endtask : chk

  // Pin follows the output a cycle late, so let it settle
  task automatic pin_is(input logic e);
    repeat (3) @(posedge ref_clk_i);
    check("pin", 32'(pin), 32'(e));
  endtask : pin_is

  // Run at full rate for a few clocks, then stop
  task automatic burst();
    wr(`ETC_A_CTRL, ctl(ETC_DIV1, ETC_NORMAL, 2'h0, 1'b0));
    repeat (6) @(posedge ref_clk_i);
    wr(`ETC_A_CTRL, ctl(ETC_STOP, ETC_NORMAL, 2'h0, 1'b0));
  endtask : burst

  // Main sequence
  initial
  begin
    repeat (12) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    check("pin", 32'(pin), 32'h0);
    for (i = 0; i < 6; i++)
      chk(5'(i * 4), 8'h00, "reset value");
    // Unmapped place, stalled answer
    rd(5'h18, 3);
    check("unmapped resp", 32'(r), 32'(`ETC_SLVERR));
    check("unmapped data", d, 32'h0);
    // Stopped counter keeps a written value
    wr(`ETC_A_COUNT, 8'h10);
    repeat (20) @(posedge ref_clk_i);
    chk(`ETC_A_COUNT, 8'h10, "stopped count");
    // Forced matches in every output mode, port value low
    wr(`ETC_A_PIN, 8'h01);
    for (i = 0; i < 7; i++)
    begin
      wr(`ETC_A_CTRL, ctl(ETC_STOP, ETC_NORMAL, tbl[i][2:1], tbl[i][3]));
      pin_is(tbl[i][0]);
    end
    check("pin enable", 32'(pin_oe), 32'h1);
    chk(`ETC_A_FLAGS, 8'h00, "forced flags");
    chk(`ETC_A_COUNT, 8'h10, "forced count");
    // Mode change keeps output; strobe ignored in PWM
    wr(`ETC_A_CTRL, ctl(ETC_STOP, ETC_FAST, 2'h2, 1'b1));
    pin_is(1'b1);
    wr(`ETC_A_COMP, 8'h40);
    chk(`ETC_A_COMP, 8'h40, "compare buffer");
    wr(`ETC_A_CTRL, ctl(ETC_STOP, ETC_NORMAL, 2'h0, 1'b0));
    chk(`ETC_A_COMP, 8'h00, "active compare");
    // Port value shows when output mode is zero
    wr(`ETC_A_PIN, 8'h03);
    pin_is(1'b1);
    wr(`ETC_A_PIN, 8'h01);
    pin_is(1'b0);
    // Normal run across the wrap
    wr(`ETC_A_COMP, 8'hFE);
    wr(`ETC_A_COUNT, 8'hFC);
    burst();
    chk(`ETC_A_FLAGS, 8'h03, "wrap flags");
    chk(`ETC_A_COUNT, 8'h05, "wrapped");
    // Requests gated by mask and cpu enable, cleared when taken
    gie <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
    check("cmp irq", 32'(cirq), 32'h0);
    wr(`ETC_A_MASK, 8'h03);
    repeat (3) @(posedge ref_clk_i);
    check("cmp irq", 32'(cirq), 32'h1);
    check("ovf irq", 32'(oirq), 32'h1);
    cack <= 1'b1;
    @(posedge ref_clk_i);
    cack <= 1'b0;
    chk(`ETC_A_FLAGS, 8'h01, "flags after ack");
    check("cmp irq", 32'(cirq), 32'h0);
    gie <= 1'b0;
    repeat (3) @(posedge ref_clk_i);
    check("ovf irq", 32'(oirq), 32'h0);
    oack <= 1'b1;
    @(posedge ref_clk_i);
    oack <= 1'b0;
    chk(`ETC_A_FLAGS, 8'h00, "flags after ack");
    // Count write equal to compare hides the next match
    wr(`ETC_A_COMP, 8'h20);
    wr(`ETC_A_COUNT, 8'h20);
    burst();
    chk(`ETC_A_FLAGS, 8'h00, "blocked match");
    wr(`ETC_A_COUNT, 8'h1E);
    burst();
    chk(`ETC_A_FLAGS, 8'h02, "match");
    wr(`ETC_A_FLAGS, 8'h02);
    chk(`ETC_A_FLAGS, 8'h00, "flag clear");
    // Clear-on-match keeps the count at or below compare
    wr(`ETC_A_COMP, 8'h05);
    wr(`ETC_A_COUNT, 8'h00);
    wr(`ETC_A_CTRL, ctl(ETC_DIV1, ETC_CTC, 2'h0, 1'b0));
    repeat (40) @(posedge ref_clk_i);
    rd(`ETC_A_COUNT, 0);
    check("ctc count", 32'(d < 32'h6), 32'h1);
    wr(`ETC_A_CTRL, ctl(ETC_STOP, ETC_CTC, 2'h0, 1'b0));
    chk(`ETC_A_FLAGS, 8'h02, "ctc flags");
    // Fast PWM moves the buffered compare in at the top
    wr(`ETC_A_CTRL, ctl(ETC_STOP, ETC_FAST, 2'h0, 1'b0));
    wr(`ETC_A_COMP, 8'h60);
    wr(`ETC_A_COUNT, 8'hFD);
    wr(`ETC_A_CTRL, ctl(ETC_DIV1, ETC_FAST, 2'h0, 1'b0));
    repeat (6) @(posedge ref_clk_i);
    wr(`ETC_A_CTRL, ctl(ETC_STOP, ETC_NORMAL, 2'h0, 1'b0));
    chk(`ETC_A_FLAGS, 8'h03, "fast flags");
    chk(`ETC_A_COMP, 8'h60, "loaded compare");
    // Divide by eight: 83 enabled clocks give ten or eleven counts
    wr(`ETC_A_COUNT, 8'h00);
    wr(`ETC_A_CTRL, ctl(ETC_DIV8, ETC_NORMAL, 2'h0, 1'b0));
    repeat (80) @(posedge ref_clk_i);
    wr(`ETC_A_CTRL, ctl(ETC_STOP, ETC_NORMAL, 2'h0, 1'b0));
    rd(`ETC_A_COUNT, 0);
    check("div8 count", 32'(d >= 32'hA && d <= 32'hB), 32'h1);
    give_verdict();
  end
endmodule : etc_timer_tb
`default_nettype wire
